// ### swlpc_pkg.sv
package swlpc_pkg;

  typedef enum logic [1:0] {
    SWLPC_RUN,
    SWLPC_STOP,
    SWLPC_STAB,
    SWLPC_WAIT
  } swlpc_state_t;

  typedef enum logic [2:0] {
    SWLPC_CAUSE_NONE,
    SWLPC_CAUSE_RESET,
    SWLPC_CAUSE_IRQ_PIN,
    SWLPC_CAUSE_PORT,
    SWLPC_CAUSE_SERIAL,
    SWLPC_CAUSE_TIMER
  } swlpc_cause_t;

endpackage : swlpc_pkg

// ### swlpc_props.sv
`timescale 1ns/10ps
module swlpc_props (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       stop_exec,
  input wire logic       wait_exec,
  input wire logic       irq_pin_event,
  input wire logic       reset_event,
  input wire logic [7:0] port_a_pins,
  input wire logic [7:0] port_c_pins,
  input wire logic [7:0] port_a_wake_en,
  input wire logic [7:0] port_c_wake_en,
  input wire logic       serial_bus_pin,
  input wire logic       timer_irq,
  input wire logic       osc_enable,
  input wire logic       cpu_clk_enable,
  input wire logic       timer_clk_enable,
  input wire logic       chip_reset_req,
  input wire logic       timer_irq_clear,
  input wire logic       timer_irq_disable,
  input wire logic       prescaler_clear,
  input wire logic       irq_mask_clear,
  input wire logic       external_interrupt_enable_set,
  input wire logic       resume,
  input wire logic [1:0] vector_sel
);
  logic [7:0]  pa_reg, pc_reg;
  logic        ps_reg, ext, wake, stopm, stab, waitm;
  logic [11:0] cnt_reg;
  logic [1:0]  vexp;
  // same reset levels as the design's edge registers, so the first edge agrees
  always_ff @(posedge aclk) begin
    pa_reg <= aresetn ? port_a_pins : 8'hFF;
    pc_reg <= aresetn ? port_c_pins : 8'hFF;
    ps_reg <= aresetn ? serial_bus_pin : 1'b0;
  end
  always_ff @(posedge aclk) begin
    cnt_reg <= (aresetn && stab) ? cnt_reg + 12'h001 : 12'h000;
  end
  assign ext = irq_pin_event | (|(pa_reg & ~port_a_pins & port_a_wake_en))
             | (|(pc_reg & ~port_c_pins & port_c_wake_en)) | (serial_bus_pin & ~ps_reg);
  assign wake = ext | reset_event;
  assign stopm = !osc_enable;
  assign stab = osc_enable & !cpu_clk_enable & !timer_clk_enable;
  assign waitm = !cpu_clk_enable & timer_clk_enable;
  assign vexp = reset_event ? 2'h0 : (ext ? 2'h1 : 2'h2);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_stop_fx;
    !osc_enable && timer_irq_clear && timer_irq_disable && prescaler_clear && irq_mask_clear
      && external_interrupt_enable_set;
  endsequence
  sequence s_chip_rst;
    chip_reset_req && cpu_clk_enable && !irq_mask_clear;
  endsequence
  a_stop_entry: assert property (cpu_clk_enable && stop_exec |=> s_stop_fx or s_chip_rst)
    else $error("stop entry wrong");
  a_osc_gates_all: assert property (stopm |-> !cpu_clk_enable && !timer_clk_enable)
    else $error("clocks run with oscillator off");
  a_stop_hold: assert property (stopm && !wake |=> stopm)
    else $error("stop left without wake");
  a_stop_wake: assert property (stopm && wake |=> stab && vector_sel == $past(vexp))
    else $error("stop wake wrong");
  a_stab_short: assert property (stab && cnt_reg < 12'hFDF |=> stab)
    else $error("stabilization too short");
  a_stab_done: assert property (stab && cnt_reg == 12'hFDF |=> cpu_clk_enable && resume)
    else $error("stabilization end wrong");
  a_wait_entry: assert property (cpu_clk_enable && wait_exec && !stop_exec |=>
    waitm && osc_enable && irq_mask_clear && !prescaler_clear) else $error("wait entry wrong");
  a_wait_hold: assert property (waitm && !wake && !timer_irq |=> waitm && !resume)
    else $error("wait left without wake");
  a_wait_exit: assert property (waitm && (wake || timer_irq) |=>
    cpu_clk_enable && resume && vector_sel == $past(vexp)) else $error("wait exit wrong");
  a_run_quiet: assert property (cpu_clk_enable && !stop_exec && !wait_exec |=>
    cpu_clk_enable && !resume && !irq_mask_clear && !chip_reset_req) else $error("run disturbed");
endmodule : swlpc_props
bind swlpc_top swlpc_props swlpc_props_inst (.*);

// ### swlpc_regs.svh
`ifndef SWLPC_REGS_SVH
`define SWLPC_REGS_SVH

// register byte offsets
`define SWLPC_CTRL_OFFSET      12'h000
`define SWLPC_STATUS_OFFSET    12'h004
`define SWLPC_COUNT_OFFSET     12'h008
`define SWLPC_ADDR_WIDTH       12

// control register fields and reset value
`define SWLPC_CTRL_STOP_EN_BIT 0
`define SWLPC_CTRL_RESET       1'b1

// status register fields
`define SWLPC_STATUS_STATE_LSB 0
`define SWLPC_STATUS_CAUSE_LSB 4

// oscillator stabilization delay in processor clock cycles (4064)
`define SWLPC_STAB_CYCLES      12'hFE0
`define SWLPC_COUNT_WIDTH      12

// axi responses
`define SWLPC_RESP_OKAY        2'h0
`define SWLPC_RESP_DECERR      2'h3

// vector selects
`define SWLPC_VEC_RESET        2'h0
`define SWLPC_VEC_EXT_IRQ      2'h1
`define SWLPC_VEC_TIMER        2'h2

// idle levels of the wake pins; edge registers reset to them
`define SWLPC_PORT_IDLE        8'hFF
`define SWLPC_SERIAL_IDLE      1'b0

`endif

// ### swlpc_top.sv
`timescale 1ns/10ps
`include "swlpc_regs.svh"
// Behaviour
// [R1] stop with option on enters stop mode; with option off it requests chip reset
// [R2] stop mode switches the oscillator off, halting all internal processing
// [R3] stop entry clears pending timer request, disables timer interrupts, clears prescaler
// [R4] stop entry clears interrupt mask bit and sets external interrupt enable
// [R5] stop touches no other register, memory or pin state
// [R6] stop exits only on irq pin, reset, enabled port falling edge, serial rise
// [R7] stop exit waits 4064 processor clocks of oscillator stabilization
// [R8] wait mode halts the processor clock
// [R9] wait mode keeps timer clocks running
// [R10] wait clears the interrupt mask bit
// [R11] wait preserves every other register, memory and pin state
// [R12] wait exits on timer irq, irq pin, reset, port fall, serial rise
// [R13] software avoids stop and wait with watchdog on, or disables stop option
// [R14] resume fetches the reset or interrupt vector matching the waking event
module swlpc_top (
  input  wire logic                            aclk,
  input  wire logic                            aresetn,
  input  wire logic [`SWLPC_ADDR_WIDTH-1:0]    s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [`SWLPC_ADDR_WIDTH-1:0]    s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic                            stop_exec,
  input  wire logic                            wait_exec,
  input  wire logic                            irq_pin_event,
  input  wire logic                            reset_event,
  input  wire logic [7:0]                      port_a_pins,
  input  wire logic [7:0]                      port_c_pins,
  input  wire logic [7:0]                      port_a_wake_en,
  input  wire logic [7:0]                      port_c_wake_en,
  input  wire logic                            serial_bus_pin,
  input  wire logic                            timer_irq,
  output logic                                 osc_enable,
  output logic                                 cpu_clk_enable,
  output logic                                 timer_clk_enable,
  output logic                                 chip_reset_req,
  output logic                                 timer_irq_clear,
  output logic                                 timer_irq_disable,
  output logic                                 prescaler_clear,
  output logic                                 irq_mask_clear,
  output logic                                 external_interrupt_enable_set,
  output logic                                 resume,
  output logic [1:0]                           vector_sel
);

  swlpc_pkg::swlpc_state_t             state_reg;
  swlpc_pkg::swlpc_cause_t             cause_reg;
  swlpc_pkg::swlpc_cause_t             cause_next;
  logic [`SWLPC_COUNT_WIDTH-1:0]       count_reg;
  logic                                stop_en_reg;
  logic [7:0]                          port_a_prev_reg;
  logic [7:0]                          port_c_prev_reg;
  logic                                serial_prev_reg;
  logic                                port_fall;
  logic                                serial_rise;
  logic                                wake_stop;
  logic                                wake_wait;
  logic                                stop_take;
  logic                                stop_refused;
  logic                                wait_take;
  logic                                wake_take;
  logic                                stab_done;
  logic                                aw_held_reg;
  logic                                w_held_reg;
  logic [`SWLPC_ADDR_WIDTH-1:0]        awaddr_reg;
  logic [31:0]                         wdata_reg;
  logic [3:0]                          wstrb_reg;
  logic                                wr_go;
  logic                                wr_hit;
  logic                                rd_hit;
  logic [31:0]                         rd_word;

  // the same decode serves both bus directions
  function automatic logic reg_hit(input logic [`SWLPC_ADDR_WIDTH-1:0] addr);
    reg_hit = (addr == `SWLPC_CTRL_OFFSET) || (addr == `SWLPC_STATUS_OFFSET) ||
              (addr == `SWLPC_COUNT_OFFSET);
  endfunction : reg_hit

  // edge registers start at the idle pin levels, so no false edge follows reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_prev_reg <= `SWLPC_PORT_IDLE;
      port_c_prev_reg <= `SWLPC_PORT_IDLE;
      serial_prev_reg <= `SWLPC_SERIAL_IDLE;
    end else begin
      port_a_prev_reg <= port_a_pins;
      port_c_prev_reg <= port_c_pins;
      serial_prev_reg <= serial_bus_pin;
    end
  end

  assign port_fall   = |(port_a_wake_en & port_a_prev_reg & ~port_a_pins) |
                       |(port_c_wake_en & port_c_prev_reg & ~port_c_pins);
  assign serial_rise = serial_bus_pin & ~serial_prev_reg;

  // timers cannot wake stop: their clocks are dead with the oscillator
  assign wake_stop = reset_event | irq_pin_event | port_fall | serial_rise; // [R6]
  assign wake_wait = wake_stop | timer_irq;                                 // [R12]

  // exec pulses count in run only; a wait that meets a stop in one cycle loses to it
  assign stop_take    = state_reg == swlpc_pkg::SWLPC_RUN && stop_exec && stop_en_reg;  // [R1]
  assign stop_refused = state_reg == swlpc_pkg::SWLPC_RUN && stop_exec && !stop_en_reg; // [R1]
  assign wait_take    = state_reg == swlpc_pkg::SWLPC_RUN && wait_exec && !stop_exec;   // [R10]
  assign wake_take    = (state_reg == swlpc_pkg::SWLPC_STOP && wake_stop) ||
                        (state_reg == swlpc_pkg::SWLPC_WAIT && wake_wait);
  assign stab_done    = state_reg == swlpc_pkg::SWLPC_STAB && count_reg == `SWLPC_STAB_CYCLES - 1'b1; // [R7]

  // highest priority cause first, reset dominating
  always_comb begin
    if (reset_event) begin
      cause_next = swlpc_pkg::SWLPC_CAUSE_RESET;
    end else if (irq_pin_event) begin
      cause_next = swlpc_pkg::SWLPC_CAUSE_IRQ_PIN;
    end else if (port_fall) begin
      cause_next = swlpc_pkg::SWLPC_CAUSE_PORT;
    end else if (serial_rise) begin
      cause_next = swlpc_pkg::SWLPC_CAUSE_SERIAL;
    end else if (timer_irq) begin
      cause_next = swlpc_pkg::SWLPC_CAUSE_TIMER;
    end else begin
      cause_next = swlpc_pkg::SWLPC_CAUSE_NONE;
    end
  end

  // mode sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= swlpc_pkg::SWLPC_RUN;
      count_reg <= '0;
    end else begin
      unique case (state_reg)
        swlpc_pkg::SWLPC_RUN: begin
          if (stop_exec && stop_en_reg) begin
            state_reg <= swlpc_pkg::SWLPC_STOP; // [R1]
          end else if (wait_exec && !stop_exec) begin
            state_reg <= swlpc_pkg::SWLPC_WAIT;
          end
        end
        swlpc_pkg::SWLPC_STOP: begin
          if (wake_stop) begin
            state_reg <= swlpc_pkg::SWLPC_STAB; // [R6]
            count_reg <= '0;
          end
        end
        swlpc_pkg::SWLPC_STAB: begin
          if (count_reg == `SWLPC_STAB_CYCLES - 1'b1) begin
            state_reg <= swlpc_pkg::SWLPC_RUN; // [R7]
          end else begin
            count_reg <= count_reg + 1'b1; // [R7]
          end
        end
        swlpc_pkg::SWLPC_WAIT: begin
          if (wake_wait) begin
            state_reg <= swlpc_pkg::SWLPC_RUN; // [R12]
          end
        end
      endcase
    end
  end

  // wake cause and vector, held for software to inspect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_reg  <= swlpc_pkg::SWLPC_CAUSE_NONE;
      vector_sel <= `SWLPC_VEC_RESET;
    end else if (wake_take) begin
      cause_reg <= cause_next;
      if (cause_next == swlpc_pkg::SWLPC_CAUSE_RESET) begin
        vector_sel <= `SWLPC_VEC_RESET; // [R14]
      end else if (cause_next == swlpc_pkg::SWLPC_CAUSE_TIMER) begin
        vector_sel <= `SWLPC_VEC_TIMER; // [R14]
      end else begin
        vector_sel <= `SWLPC_VEC_EXT_IRQ; // [R14]
      end
    end
  end

  // stop entry effects, one cycle each; apart from these and the mask bit nothing in the chip is touched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq_clear               <= 1'b0;
      timer_irq_disable             <= 1'b0;
      prescaler_clear               <= 1'b0;
      external_interrupt_enable_set <= 1'b0;
    end else begin
      timer_irq_clear               <= stop_take; // [R3]
      timer_irq_disable             <= stop_take; // [R3]
      prescaler_clear               <= stop_take; // [R3]
      external_interrupt_enable_set <= stop_take; // [R4]
    end
  end

  // the mask bit is the only processor state both modes alter; for wait it is the only one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_clear <= 1'b0;
    end else begin
      irq_mask_clear <= stop_take || wait_take; // [R4] [R10] [R5] [R11]
    end
  end

  // with the option off the mode stays run and only a reset request goes out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_reset_req <= 1'b0;
    end else begin
      chip_reset_req <= stop_refused; // [R1]
    end
  end

  // resume marks the first processor cycle; vector_sel already stands by then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume <= 1'b0;
    end else begin
      resume <= stab_done || (state_reg == swlpc_pkg::SWLPC_WAIT && wake_wait); // [R14]
    end
  end

  // clock gating follows the mode directly
  assign osc_enable       = state_reg != swlpc_pkg::SWLPC_STOP; // [R2]
  assign cpu_clk_enable   = state_reg == swlpc_pkg::SWLPC_RUN; // [R8]
  assign timer_clk_enable = state_reg == swlpc_pkg::SWLPC_RUN ||
                            state_reg == swlpc_pkg::SWLPC_WAIT; // [R9]

  // axi write: address and data taken in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_go         = aw_held_reg && w_held_reg;
  assign wr_hit        = reg_hit(awaddr_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SWLPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SWLPC_RESP_OKAY : `SWLPC_RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // stop option: stands in for the mask option, software may change it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_en_reg <= `SWLPC_CTRL_RESET;
    end else if (wr_go && awaddr_reg == `SWLPC_CTRL_OFFSET && wstrb_reg[0]) begin
      stop_en_reg <= wdata_reg[`SWLPC_CTRL_STOP_EN_BIT]; // [R1]
    end
  end

  // axi read
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit        = reg_hit(s_axi_araddr);

  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == `SWLPC_CTRL_OFFSET) begin
      rd_word[`SWLPC_CTRL_STOP_EN_BIT] = stop_en_reg;
    end else if (s_axi_araddr == `SWLPC_STATUS_OFFSET) begin
      rd_word[`SWLPC_STATUS_STATE_LSB +: 2] = state_reg;
      rd_word[`SWLPC_STATUS_CAUSE_LSB +: 3] = cause_reg;
    end else if (s_axi_araddr == `SWLPC_COUNT_OFFSET) begin
      rd_word[`SWLPC_COUNT_WIDTH-1:0] = count_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SWLPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `SWLPC_RESP_OKAY : `SWLPC_RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : swlpc_top

// ### swlpc_wake_src.sv
`timescale 1ns/10ps
module swlpc_wake_src (
  input wire logic       aclk,
  input wire logic       go,
  input wire logic [2:0] kind,
  input wire logic [2:0] sel,
  input wire logic [3:0] dly,
  output logic           irq_pin_event,
  output logic           reset_event,
  output logic [7:0]     port_a_pins,
  output logic [7:0]     port_c_pins,
  output logic           serial_bus_pin,
  output logic           timer_irq
);
  logic [4:0] cnt;
  logic [2:0] k;
  initial begin
    {irq_pin_event, reset_event, serial_bus_pin, timer_irq, cnt, k} = '0;
    {port_a_pins, port_c_pins} = 16'hFFFF;
  end
  // every source returns to its pulled idle level one cycle after an event
  always @(posedge aclk) begin
    {irq_pin_event, reset_event, serial_bus_pin, timer_irq} <= 4'h0;
    {port_a_pins, port_c_pins} <= 16'hFFFF;
    cnt <= (cnt != 5'h00) ? cnt - 5'h01 : 5'h00;
    if (go) begin
      cnt <= {1'b0, dly} + 5'h01;
      k <= kind;
    end
    case ((cnt == 5'h01) ? k : 3'h0)
      3'h1: irq_pin_event <= 1'b1;
      3'h2: reset_event <= 1'b1;
      3'h3: port_a_pins <= ~(8'h01 << sel);
      3'h4: port_c_pins <= ~(8'h01 << sel);
      3'h5: serial_bus_pin <= 1'b1;
      3'h6: timer_irq <= 1'b1;
      default: ;
    endcase
  end
endmodule : swlpc_wake_src

// ### tb_stop_wait_lowpower_control.sv
`timescale 1ns/10ps
`include "swlpc_regs.svh"
module tb_stop_wait_lowpower_control;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, stop_exec, wait_exec, irq_pin_event, go;
  logic reset_event, serial_bus_pin, timer_irq, osc_enable, cpu_clk_enable, timer_clk_enable, chip_reset_req;
  logic timer_irq_clear, timer_irq_disable, prescaler_clear, irq_mask_clear, external_interrupt_enable_set, resume;
  logic [`SWLPC_ADDR_WIDTH-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, dly;
  logic [1:0]  s_axi_bresp, s_axi_rresp, vector_sel, rsp;
  logic [7:0]  port_a_pins, port_c_pins, port_a_wake_en, port_c_wake_en;
  logic [2:0]  kind, sel;
  logic [2:0]  exp_q[$];
  int          errors, comparisons, cycles;
  swlpc_top swlpc_top_inst (.*);
  swlpc_wake_src swlpc_wake_src_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  function automatic logic [2:0] cause_of(input int k);
    // partner wake kinds 1..6 against the status cause codes
    cause_of = (k == 1) ? 3'h2 : (k == 2) ? 3'h1 : (k == 5) ? 3'h4 : (k == 6) ? 3'h5 : 3'h3;
  endfunction : cause_of
  task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw, w, b;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      {b, rsp} = {s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check({30'h0, rsp}, {30'h0, e});
  endtask : axi_wr
  task axi_rd(input logic [11:0] a, input logic [1:0] e);
    logic ar, r;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      {r, rd, rsp} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check({30'h0, rsp}, {30'h0, e});
  endtask : axi_rd
  task mode(input logic s);
    @(posedge aclk);
    {stop_exec, wait_exec} <= {s, !s};
    @(posedge aclk);
    {stop_exec, wait_exec} <= 2'h0;
  endtask : mode
  task fire(input logic [2:0] k, input logic [2:0] v);
    logic [2:0] s;
    s = 3'($urandom);
    @(posedge aclk);
    {kind, sel, dly, go} <= {k, s, 4'($urandom), 1'b1};
    port_a_wake_en <= 8'($urandom) | (8'h01 << s);
    port_c_wake_en <= 8'($urandom) | (8'h01 << s);
    if (v != 3'h7) exp_q.push_back(v);
    @(posedge aclk);
    go <= 1'b0;
  endtask : fire
  initial begin
    {aresetn, stop_exec, wait_exec, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, kind, sel, dly, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {port_a_wake_en, port_c_wake_en, s_axi_wstrb} = {16'h0, 4'hF};
    void'($urandom(32'hB520));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`SWLPC_CTRL_OFFSET, `SWLPC_RESP_OKAY);
    check(rd, 32'h1);
    axi_rd(12'h00C, `SWLPC_RESP_DECERR);
    check(rd, 32'h0);
    axi_wr(12'h00C, 32'h0, `SWLPC_RESP_DECERR);
    for (int k = 1; k <= 5; k++) begin
      mode(1'b1);
      axi_rd(`SWLPC_STATUS_OFFSET, `SWLPC_RESP_OKAY);
      check({30'h0, rd[1:0]}, 32'h1);
      // timer request must not end stop; only the later event may
      fire(3'h6, 3'h7);
      repeat (20) @(posedge aclk);
      fire(3'(k), (k == 2) ? 3'h0 : 3'h1);
      while (exp_q.size() != 0) @(posedge aclk);
      axi_rd(`SWLPC_STATUS_OFFSET, `SWLPC_RESP_OKAY);
      check(rd, {25'h0, cause_of(k), 4'h0});
      // recovery counts 0 to 4063 and the count then rests at its last value
      axi_rd(`SWLPC_COUNT_OFFSET, `SWLPC_RESP_OKAY);
      check(rd, 32'h0000_0FDF);
    end
    for (int k = 1; k <= 6; k++) begin
      mode(1'b0);
      fire(3'(k), (k == 2) ? 3'h0 : ((k == 6) ? 3'h2 : 3'h1));
      while (exp_q.size() != 0) @(posedge aclk);
      axi_rd(`SWLPC_STATUS_OFFSET, `SWLPC_RESP_OKAY);
      check(rd, {25'h0, cause_of(k), 4'h0});
    end
    axi_wr(`SWLPC_CTRL_OFFSET, 32'h0, `SWLPC_RESP_OKAY);
    axi_rd(`SWLPC_CTRL_OFFSET, `SWLPC_RESP_OKAY);
    check(rd, 32'h0);
    exp_q.push_back(3'h4);
    mode(1'b1);
    repeat (4) @(posedge aclk);
    check(exp_q.size(), 32'h0);
    axi_rd(`SWLPC_STATUS_OFFSET, `SWLPC_RESP_OKAY);
    check({30'h0, rd[1:0]}, 32'h0);
    report_and_stop();
  end
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && (resume === 1'b1 || chip_reset_req === 1'b1))
      check({29'h0, chip_reset_req ? 3'h4 : {1'b0, vector_sel}}, {29'h0, (exp_q.size() != 0) ? exp_q.pop_front() : 3'h7});
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end
endmodule : tb_stop_wait_lowpower_control
